// ===== byte_arith_pkg.sv
/*
 Constants, opcodes and register map of the byte arithmetic unit.
 Assumes one core clock and a decoder that presents one opcode per cycle.
*/
package byte_arith_pkg;

    localparam int BYTE_W = 8;
    localparam int FLAG_W = 4;
    localparam int ADDR_W = 2;

    // Register port map
    localparam logic [ADDR_W-1:0] OFS_WORK = 2'h0;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 2'h1;

    // Flag field positions inside the flag register
    localparam int FLAG_Z_BIT = 0;
    localparam int FLAG_C_BIT = 1;
    localparam int FLAG_HALF_BIT = 2;
    localparam int FLAG_WRAP_BIT = 3;

    localparam logic [BYTE_W-1:0] WORK_RESET = 8'h00;
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 4'h0;
    localparam logic [BYTE_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [BYTE_W-1:0] ONE_BYTE = 8'h01;

    typedef enum logic [4:0] {
        OP_ADD_AI = 5'h00,
        OP_ADD_AM = 5'h01,
        OP_ADD_MA = 5'h02,
        OP_ADDC_AM = 5'h03,
        OP_ADDC_MA = 5'h04,
        OP_ADDC_A = 5'h05,
        OP_ADDC_M = 5'h06,
        OP_NADD_AM = 5'h07,
        OP_NADD_MA = 5'h08,
        OP_SUB_AI = 5'h09,
        OP_SUB_AM = 5'h0a,
        OP_SUB_MA = 5'h0b,
        OP_SUBC_AM = 5'h0c,
        OP_SUBC_MA = 5'h0d,
        OP_SUBC_A = 5'h0e,
        OP_SUBC_M = 5'h0f,
        OP_INC_M = 5'h10,
        OP_DEC_M = 5'h11,
        OP_CLR_M = 5'h12
    } op_t;

endpackage

// ===== byte_arithmetic_unit.sv
/*
 Byte arithmetic datapath: add, subtract, carry forms, increment,
 decrement and clear on the work register and one memory byte.
 Assumes the decoder holds MEM_RDATA valid beside OP_VALID, and that
 memory takes MEM_WDATA while MEM_WE is high.
*/
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps

// How it works
// - Add immediate into work register, all flags
// - Add memory byte into work or memory
// - Add memory plus carry into work or memory
// - Add carry alone to work register
// - Add carry alone to memory byte
// - Memory minus work into work register
// - Work minus memory into memory byte
// - Work minus immediate into work register
// - Work minus memory into work register
// - Memory minus work into memory byte
// - Work minus memory minus carry into work
// - Memory minus work minus carry into memory
// - Subtract carry alone from work register
// - Subtract carry alone from memory byte
// - Increment memory byte, all flags
// - Decrement memory byte, all flags
// - Clear memory byte, flags untouched
module byte_arithmetic_unit (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic OP_VALID,
    input wire byte_arith_pkg::op_t OP_CODE,
    input wire logic [byte_arith_pkg::BYTE_W-1:0] IMM,
    input wire logic [byte_arith_pkg::BYTE_W-1:0] MEM_RDATA,
    output logic [byte_arith_pkg::BYTE_W-1:0] MEM_WDATA,
    output logic MEM_WE,
    output logic [byte_arith_pkg::BYTE_W-1:0] WORK_REG,
    output logic FLAG_Z,
    output logic FLAG_C,
    output logic FLAG_HALF,
    output logic FLAG_WRAP,
    input wire logic [byte_arith_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [byte_arith_pkg::BYTE_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [byte_arith_pkg::BYTE_W-1:0] REG_RDATA
);
    import byte_arith_pkg::*;

    logic [BYTE_W-1:0] work_q;
    logic [FLAG_W-1:0] flags_q;
    logic [BYTE_W-1:0] mem_wdata_q;
    logic mem_we_q;
    logic [BYTE_W-1:0] rdata_q;

    logic [BYTE_W-1:0] opa;
    logic [BYTE_W-1:0] opb;
    logic is_sub;
    logic use_carry;
    logic to_mem;
    logic flag_upd;
    logic legal;
    logic [FLAG_W+BYTE_W-1:0] alu_out;
    logic carry_in;

    // One adder serves every form: subtraction adds the inverted operand
    function automatic logic [FLAG_W+BYTE_W-1:0] alu_f(
        input logic [BYTE_W-1:0] x,
        input logic [BYTE_W-1:0] y,
        input logic sub,
        input logic cin
    );
        logic [BYTE_W-1:0] yy;
        logic ci;
        logic [4:0] low;
        logic [BYTE_W:0] full;
        logic [FLAG_W-1:0] f;
        yy = sub ? ~y : y;
        ci = sub ? ~cin : cin;
        low = {1'b0, x[3:0]} + {1'b0, yy[3:0]} + {4'h0, ci};
        full = {1'b0, x} + {1'b0, yy} + {8'h00, ci};
        f[FLAG_Z_BIT] = (full[BYTE_W-1:0] == ZERO_BYTE);
        f[FLAG_C_BIT] = full[BYTE_W] ^ sub;
        f[FLAG_HALF_BIT] = low[4] ^ sub;
        f[FLAG_WRAP_BIT] = (x[BYTE_W-1] == yy[BYTE_W-1]) &&
                         (full[BYTE_W-1] != x[BYTE_W-1]);
        return {f, full[BYTE_W-1:0]};
    endfunction

    always_comb begin
        opa = work_q;
        opb = IMM;
        is_sub = 1'b0;
        use_carry = 1'b0;
        to_mem = 1'b0;
        flag_upd = 1'b1;
        legal = 1'b1;
        case (OP_CODE)
            OP_ADD_AI: begin
                opb = IMM;
            end
            OP_ADD_AM: begin
                opb = MEM_RDATA;
            end
            OP_ADD_MA: begin
                opb = MEM_RDATA;
                to_mem = 1'b1;
            end
            OP_ADDC_AM: begin
                opb = MEM_RDATA;
                use_carry = 1'b1;
            end
            OP_ADDC_MA: begin
                opb = MEM_RDATA;
                use_carry = 1'b1;
                to_mem = 1'b1;
            end
            OP_ADDC_A: begin
                opb = ZERO_BYTE;
                use_carry = 1'b1;
            end
            OP_ADDC_M: begin
                opa = MEM_RDATA;
                opb = ZERO_BYTE;
                use_carry = 1'b1;
                to_mem = 1'b1;
            end
            OP_NADD_AM: begin
                opa = MEM_RDATA;
                opb = work_q;
                is_sub = 1'b1;
            end
            OP_NADD_MA: begin
                opb = MEM_RDATA;
                is_sub = 1'b1;
                to_mem = 1'b1;
            end
            OP_SUB_AI: begin
                opb = IMM;
                is_sub = 1'b1;
            end
            OP_SUB_AM: begin
                opb = MEM_RDATA;
                is_sub = 1'b1;
            end
            OP_SUB_MA: begin
                opa = MEM_RDATA;
                opb = work_q;
                is_sub = 1'b1;
                to_mem = 1'b1;
            end
            OP_SUBC_AM: begin
                opb = MEM_RDATA;
                is_sub = 1'b1;
                use_carry = 1'b1;
            end
            OP_SUBC_MA: begin
                opa = MEM_RDATA;
                opb = work_q;
                is_sub = 1'b1;
                use_carry = 1'b1;
                to_mem = 1'b1;
            end
            OP_SUBC_A: begin
                opb = ZERO_BYTE;
                is_sub = 1'b1;
                use_carry = 1'b1;
            end
            OP_SUBC_M: begin
                opa = MEM_RDATA;
                opb = ZERO_BYTE;
                is_sub = 1'b1;
                use_carry = 1'b1;
                to_mem = 1'b1;
            end
            OP_INC_M: begin
                opa = MEM_RDATA;
                opb = ONE_BYTE;
                to_mem = 1'b1;
            end
            OP_DEC_M: begin
                opa = MEM_RDATA;
                opb = ONE_BYTE;
                is_sub = 1'b1;
                to_mem = 1'b1;
            end
            OP_CLR_M: begin
                opa = ZERO_BYTE;
                opb = ZERO_BYTE;
                to_mem = 1'b1;
                flag_upd = 1'b0;
            end
            default: begin
                legal = 1'b0;
                flag_upd = 1'b0;
            end
        endcase
    end

    assign carry_in = use_carry & flags_q[FLAG_C_BIT];
    assign alu_out = alu_f(opa, opb, is_sub, carry_in);

    // An operation in the same cycle as a register write wins
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            work_q <= WORK_RESET;
        end else if (OP_VALID && legal && !to_mem) begin
            work_q <= alu_out[BYTE_W-1:0];
        end else if (REG_WR && REG_ADDR == OFS_WORK) begin
            work_q <= REG_WDATA;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            flags_q <= FLAGS_RESET;
        end else if (OP_VALID && flag_upd) begin
            flags_q <= alu_out[FLAG_W+BYTE_W-1:BYTE_W];
        end else if (REG_WR && REG_ADDR == OFS_FLAGS) begin
            flags_q <= REG_WDATA[FLAG_W-1:0];
        end
    end

    // Clear needs no special path: the adder yields zero for it
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            mem_we_q <= 1'b0;
            mem_wdata_q <= ZERO_BYTE;
        end else begin
            mem_we_q <= OP_VALID && legal && to_mem;
            if (OP_VALID && legal && to_mem) begin
                mem_wdata_q <= alu_out[BYTE_W-1:0];
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            rdata_q <= ZERO_BYTE;
        end else if (REG_RD) begin
            case (REG_ADDR)
                OFS_WORK: rdata_q <= work_q;
                OFS_FLAGS: rdata_q <= {{(BYTE_W-FLAG_W){1'b0}}, flags_q};
                default: rdata_q <= ZERO_BYTE;
            endcase
        end else begin
            rdata_q <= ZERO_BYTE;
        end
    end

    assign WORK_REG = work_q;
    assign MEM_WDATA = mem_wdata_q;
    assign MEM_WE = mem_we_q;
    assign FLAG_Z = flags_q[FLAG_Z_BIT];
    assign FLAG_C = flags_q[FLAG_C_BIT];
    assign FLAG_HALF = flags_q[FLAG_HALF_BIT];
    assign FLAG_WRAP = flags_q[FLAG_WRAP_BIT];
    assign REG_RDATA = rdata_q;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    sequence s_issue(op_t op);
        OP_VALID && OP_CODE == op;
    endsequence

    sequence s_mem_write(logic [BYTE_W-1:0] v);
        MEM_WE && MEM_WDATA == v;
    endsequence

    property p_add_imm;
        s_issue(OP_ADD_AI) |=>
            WORK_REG == 8'($past(WORK_REG) + $past(IMM));
    endproperty
    a_add_imm: assert property (p_add_imm)
        else $error("add immediate result wrong");

    property p_add_to_mem;
        logic [BYTE_W-1:0] v;
        (s_issue(OP_ADD_MA), v = 8'(WORK_REG + MEM_RDATA)) |=>
            s_mem_write(v) ##1 (!MEM_WE || $past(OP_VALID));
    endproperty
    a_add_to_mem: assert property (p_add_to_mem)
        else $error("add into memory wrong");

    property p_addc_work;
        s_issue(OP_ADDC_A) |=>
            WORK_REG == 8'($past(WORK_REG) + {7'h00, $past(FLAG_C)});
    endproperty
    a_addc_work: assert property (p_addc_work)
        else $error("add carry to work register wrong");

    property p_sub_borrow;
        s_issue(OP_SUB_AI) |=> FLAG_C == ($past(WORK_REG) < $past(IMM));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow)
        else $error("subtract borrow flag wrong");

    property p_subc_mem;
        logic [BYTE_W-1:0] v;
        (s_issue(OP_SUBC_M), v = 8'(MEM_RDATA - {7'h00, FLAG_C})) |=>
            s_mem_write(v);
    endproperty
    a_subc_mem: assert property (p_subc_mem)
        else $error("subtract carry from memory wrong");

    property p_inc_mem;
        logic [BYTE_W-1:0] v;
        (s_issue(OP_INC_M), v = 8'(MEM_RDATA + ONE_BYTE)) |=>
            s_mem_write(v) ##0 FLAG_Z == (v == ZERO_BYTE);
    endproperty
    a_inc_mem: assert property (p_inc_mem)
        else $error("increment wrong");

    property p_dec_mem;
        s_issue(OP_DEC_M) |=> MEM_WE &&
            MEM_WDATA == 8'($past(MEM_RDATA) - ONE_BYTE) &&
            FLAG_C == ($past(MEM_RDATA) == ZERO_BYTE);
    endproperty
    a_dec_mem: assert property (p_dec_mem)
        else $error("decrement wrong");

    property p_clear_mem;
        s_issue(OP_CLR_M) ##0 !REG_WR |=>
            s_mem_write(ZERO_BYTE) ##0 $stable(flags_q);
    endproperty
    a_clear_mem: assert property (p_clear_mem)
        else $error("clear wrong or flags moved");

    property p_zero_flag;
        OP_VALID && flag_upd |=> FLAG_Z == ($past(alu_out[7:0]) == 8'h00);
    endproperty
    a_zero_flag: assert property (p_zero_flag)
        else $error("zero flag disagrees with result");

endmodule // byte_arithmetic_unit

// ===== mem_model.sv
/*
 Data memory byte that feeds the arithmetic unit's memory operand.
 Assumes the bench presets the byte between operations.
*/
`timescale 1ns/100ps
module mem_model (
    input wire logic clk,
    input wire logic rd,
    input wire logic we,
    input wire logic [7:0] wdata,
    input wire logic ld,
    input wire logic [7:0] ld_data,
    output logic [7:0] rdata
);
    logic [7:0] byte_q;
    always_ff @(posedge clk) begin
        if (ld) begin
            byte_q <= ld_data;
        end else if (we) begin
            byte_q <= wdata;
        end
    end
    // Bus not read shows garbage, never a stale byte
    assign rdata = rd ? byte_q : ~byte_q;
endmodule // mem_model

// ===== test_byte_arithmetic_unit.sv
/*
 Self-checking bench for the byte arithmetic unit.
 Assumes results land one cycle after the request.
*/
`timescale 1ns/100ps
module test_byte_arithmetic_unit;
    import byte_arith_pkg::*;
    logic CORE_CLK = 1'b0;
    logic RST = 1'b1;
    logic OP_VALID = 1'b0;
    op_t OP_CODE = OP_ADD_AI;
    logic [7:0] IMM = 8'h00;
    logic [1:0] REG_ADDR = 2'h0;
    logic [7:0] REG_WDATA = 8'h00;
    logic REG_WR = 1'b0, REG_RD = 1'b0, ld = 1'b0;
    logic [7:0] ld_data = 8'h00;
    logic [7:0] MEM_RDATA, MEM_WDATA, WORK_REG, REG_RDATA;
    logic MEM_WE, FLAG_Z, FLAG_C, FLAG_HALF, FLAG_WRAP;
    logic [7:0] ew = 8'h00, em = 8'h00, erd = 8'h00;
    logic [3:0] ef = 4'h0;
    logic ewe = 1'b0, mon = 1'b0;
    int err_total = 0, comparisons = 0, cycles = 0;
    // Seeds hit wrap, overflow, nibble carry and zero
    logic [7:0] wv [4] = '{8'h7f, 8'h80, 8'h0f, 8'h00};
    logic [7:0] mv [4] = '{8'h01, 8'h80, 8'hf1, 8'hff};
    logic [7:0] iv [4] = '{8'h01, 8'h80, 8'h71, 8'hff};
    logic [3:0] fv [4] = '{4'h0, 4'h2, 4'h2, 4'hf};

    byte_arithmetic_unit byte_arithmetic_unit_i (
        .CORE_CLK(CORE_CLK), .RST(RST), .OP_VALID(OP_VALID),
        .OP_CODE(OP_CODE), .IMM(IMM), .MEM_RDATA(MEM_RDATA),
        .MEM_WDATA(MEM_WDATA), .MEM_WE(MEM_WE), .WORK_REG(WORK_REG),
        .FLAG_Z(FLAG_Z), .FLAG_C(FLAG_C), .FLAG_HALF(FLAG_HALF),
        .FLAG_WRAP(FLAG_WRAP), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA)
    );
    mem_model mem_model_i (
        .clk(CORE_CLK), .rd(OP_VALID), .we(MEM_WE), .wdata(MEM_WDATA),
        .ld(ld), .ld_data(ld_data), .rdata(MEM_RDATA)
    );

    initial begin
        forever #4 CORE_CLK = ~CORE_CLK;
    end

    task automatic end_of_test();
        if (err_total == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string n, input logic [7:0] s,
                         input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    // Mid-cycle, so every edge update has landed
    always @(negedge CORE_CLK) begin
        if (mon) begin
            check("work", WORK_REG, ew);
            check("flags", {4'h0, FLAG_WRAP, FLAG_HALF, FLAG_C, FLAG_Z},
                  {4'h0, ef});
            check("mem_we", {7'h0, MEM_WE}, {7'h0, ewe});
            check("reg_rdata", REG_RDATA, erd);
            if (ewe) begin
                check("mem_wdata", MEM_WDATA, em);
            end
        end
    end

    always @(posedge CORE_CLK) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic put(input logic v, input logic w, input logic r,
                       input logic l);
        OP_VALID <= v;
        REG_WR <= w;
        REG_RD <= r;
        ld <= l;
    endtask

    task automatic tail(input logic we, input logic [7:0] rd);
        ewe = we;
        erd = rd;
    endtask

    task automatic idle();
        put(1'b0, 1'b0, 1'b0, 1'b0);
        @(posedge CORE_CLK);
        tail(1'b0, 8'h00);
    endtask

    task automatic mem(input logic [7:0] d);
        put(1'b0, 1'b0, 1'b0, 1'b1);
        ld_data <= d;
        @(posedge CORE_CLK);
        em = d;
        tail(1'b0, 8'h00);
    endtask

    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        put(1'b0, 1'b1, 1'b0, 1'b0);
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CORE_CLK);
        if (a == OFS_WORK) ew = d;
        if (a == OFS_FLAGS) ef = d[3:0];
        tail(1'b0, 8'h00);
    endtask

    task automatic reg_rd(input logic [1:0] a);
        put(1'b0, 1'b0, 1'b1, 1'b0);
        REG_ADDR <= a;
        @(posedge CORE_CLK);
        tail(1'b0, a == OFS_WORK ? ew : a == OFS_FLAGS ? {4'h0, ef} : 8'h00);
    endtask

    task automatic op(input op_t o, input logic [7:0] i);
        logic [7:0] x, y, r;
        logic [8:0] s;
        logic [4:0] h;
        logic ci, sb, wm, xm;
        put(1'b1, 1'b0, 1'b0, 1'b0);
        OP_CODE <= o;
        IMM <= i;
        @(posedge CORE_CLK);
        tail(1'b0, 8'h00);
        if (o > OP_CLR_M) return;
        if (o == OP_CLR_M) begin
            em = 8'h00;
            ewe = 1'b1;
            return;
        end
        wm = o inside {OP_ADD_MA, OP_ADDC_MA, OP_ADDC_M, OP_NADD_MA,
            OP_SUB_MA, OP_SUBC_MA, OP_SUBC_M, OP_INC_M, OP_DEC_M};
        sb = o inside {[OP_NADD_AM:OP_SUBC_M], OP_DEC_M};
        ci = o inside {[OP_ADDC_AM:OP_ADDC_M], [OP_SUBC_AM:OP_SUBC_M]};
        ci = ci & ef[1];
        xm = o inside {OP_ADDC_M, OP_NADD_AM, OP_SUB_MA, OP_SUBC_MA,
            OP_SUBC_M, OP_INC_M, OP_DEC_M};
        x = xm ? em : ew;
        y = xm ? ew : em;
        if (o inside {OP_ADD_AI, OP_SUB_AI}) y = i;
        if (o inside {OP_ADDC_A, OP_ADDC_M, OP_SUBC_A, OP_SUBC_M}) y = 8'h00;
        if (o inside {OP_INC_M, OP_DEC_M}) y = 8'h01;
        if (sb) begin
            s = {1'b0, x} - {1'b0, y} - {8'h00, ci};
            h = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, ci};
        end else begin
            s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
            h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
        end
        r = s[7:0];
        ef = {(x[7] ^ r[7]) & (x[7] ^ y[7] ^ ~sb), h[4], s[8], r == 8'h00};
        if (wm) em = r;
        else ew = r;
        ewe = wm;
    endtask

    task automatic run(input op_t o, input int k);
        reg_wr(OFS_WORK, wv[k]);
        reg_wr(OFS_FLAGS, {4'h0, fv[k]});
        mem(mv[k]);
        op(o, iv[k]);
        idle();
    endtask

    task automatic t_regs();
        reg_wr(OFS_WORK, 8'h5a);
        reg_rd(OFS_WORK);
        reg_wr(OFS_FLAGS, 8'hff);
        reg_rd(OFS_FLAGS);
        reg_wr(2'h3, 8'h11);
        reg_rd(2'h2);
        reg_rd(OFS_WORK);
        idle();
    endtask

    task automatic t_ops();
        for (int k = 0; k < 4; k++) begin
            run(OP_ADD_AI, k);
            run(OP_ADD_AM, k);
            run(OP_ADD_MA, k);
            run(OP_ADDC_AM, k);
            run(OP_ADDC_MA, k);
            run(OP_ADDC_A, k);
            run(OP_ADDC_M, k);
            run(OP_NADD_AM, k);
            run(OP_NADD_MA, k);
            run(OP_SUB_AI, k);
            run(OP_SUB_AM, k);
            run(OP_SUB_MA, k);
            run(OP_SUBC_AM, k);
            run(OP_SUBC_MA, k);
            run(OP_SUBC_A, k);
            run(OP_SUBC_M, k);
            run(OP_INC_M, k);
            run(OP_DEC_M, k);
            run(OP_CLR_M, k);
        end
    endtask

    task automatic t_back();
        reg_wr(OFS_WORK, 8'hff);
        mem(8'h00);
        op(OP_ADD_AI, 8'h01);
        op(OP_ADDC_A, 8'h00);
        op(OP_SUBC_A, 8'h00);
        op(OP_CLR_M, 8'h00);
        op(op_t'(5'h1f), 8'h33);
        idle();
    endtask

    task automatic t_rst();
        put(1'b0, 1'b0, 1'b0, 1'b0);
        RST <= 1'b1;
        @(posedge CORE_CLK);
        RST <= 1'b0;
        ew = WORK_RESET;
        ef = FLAGS_RESET;
        tail(1'b0, 8'h00);
        idle();
    endtask

    initial begin
        repeat (2) @(posedge CORE_CLK);
        mon = 1'b1;
        RST <= 1'b0;
        t_regs();
        t_ops();
        t_back();
        t_rst();
        t_back();
        end_of_test();
    end
endmodule // test_byte_arithmetic_unit
